/* File: rtl/asuart_pkg.sv */
package asuart_pkg;
  // register byte addresses
  localparam logic [2:0] ADDR_MODE   = 3'h0;
  localparam logic [2:0] ADDR_BAUD   = 3'h1;
  localparam logic [2:0] ADDR_TB_LO  = 3'h2;
  localparam logic [2:0] ADDR_TB_HI  = 3'h3;
  localparam logic [2:0] ADDR_CTL0   = 3'h4;
  localparam logic [2:0] ADDR_CTL1   = 3'h5;
  localparam logic [2:0] ADDR_RB_LO  = 3'h6;
  localparam logic [2:0] ADDR_RB_HI  = 3'h7;
  // serial_mode_reg fields
  localparam int MR_CLOCK_SOURCE_SEL  = 3;
  localparam int MR_STOP   = 4;
  localparam int MR_PEVEN  = 5;
  localparam int MR_PEN    = 6;
  // serial_control_zero fields
  localparam int C0_SHEMPTY = 3;
  localparam int C0_ODRAIN  = 5;
  localparam int C0_CKEDGE  = 6;
  localparam int C0_MSBF    = 7;
  // serial_control_one fields
  localparam int C1_TXEN   = 0;
  localparam int C1_TBE    = 1;
  localparam int C1_RXEN   = 2;
  localparam int C1_RXDONE = 3;
  localparam int C1_TXISEL = 4;
  localparam int C1_CONTRX = 5;
  // rx_buffer upper byte fields
  localparam int RB_OVR  = 4;
  localparam int RB_FER  = 5;
  localparam int RB_PER  = 6;
  localparam int RB_SUM  = 7;
  // mode codes
  localparam logic [2:0] MODE_7BIT = 3'h4;
  localparam logic [2:0] MODE_8BIT = 3'h5;
  localparam logic [2:0] MODE_9BIT = 3'h6;
  // count source codes and prescale
  localparam logic [1:0] SRC_F1  = 2'h0;
  localparam logic [1:0] SRC_F8  = 2'h1;
  localparam logic [4:0] PRE_F8  = 5'h07;
  localparam logic [4:0] PRE_F32 = 5'h1f;
  // oversampling
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID  = 4'h7;
  // reset values
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_BAUD = 8'h00;
  localparam logic [7:0] RST_CTL0 = 8'h00;
  localparam logic [7:0] RST_CTL1 = 8'h00;
endpackage : asuart_pkg

/* File: rtl/asuart_top.sv */
// Overview of operation
// (R1) start bit then 7, 8 or 9 bits
// (R2) parity odd, even or none
// (R3) one or two stop bits sent
// (R4) internal source f1/f8/f32 over 16(n+1)
// (R5) external clock pin over 16(n+1)
// (R6) transmit when enabled and data waiting
// (R7) receive when enabled and start seen
// (R8) tx request on buffer transfer, select 0
// (R9) tx request on shift done, select 1
// (R10) rx request when buffer loaded
// (R11) overrun when new char meets unread
// (R12) overrun keeps request, data undefined
// (R13) framing error on missing stop bit
// (R14) parity error on ones mismatch
// (R15) error sum on any error
// (R16) software sets mode 100b/101b/110b
// (R17) msb first only for 8 bits
// (R18) buffer bits 0-6, 0-7, 0-8 used
// (R19) idle line high or released
// (R20) upper rx read clears errors, done; code leaves overrun set until receive disabled
// (R21) nine bits: upper byte written first
// (R22) falling edge start, mid-bit sampling
// (R23) buffer and shift empty flags
module asuart_top (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  // register port
  input  wire logic [2:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // serial pins
  input  wire logic       serial_in_pin_i,
  input  wire logic       serial_clock_pin_i,
  output logic            serial_out_pin_o,
  output logic            serial_out_pin_oe_o,
  // event pulses
  output logic            tx_irq_o,
  output logic            rx_irq_o
);
  import asuart_pkg::*;

  // transmit and receive states
  typedef enum logic [4:0] {
    ASU_IDLE  = 5'h01,
    ASU_START = 5'h02,
    ASU_DATA  = 5'h04,
    ASU_PAR   = 5'h08,
    ASU_STOP  = 5'h10
  } asu_state_e;

  logic       rst_s1_q;              // reset release stage one
  logic       rst_n;                 // released reset copy
  logic [7:0] mode_q;                // serial_mode_reg
  logic [7:0] baud_q;                // baud_divider
  logic [7:0] ctl0_q;                // serial_control_zero stored bits
  logic [7:0] ctl1_q;                // serial_control_one stored bits
  logic [8:0] tb_q;                  // tx_buffer
  logic       tbe_q;                 // tx_buffer_empty_flag
  logic       shemp_q;               // shift_empty_flag
  logic [8:0] rb_q;                  // rx_buffer data
  logic       rxdone_q;              // rx_complete_flag
  logic       ovr_q;                 // overrun_flag
  logic       fer_q;                 // framing_error_flag
  logic       per_q;                 // parity_error_flag
  logic [4:0] pre_q;                 // f8/f32 prescaler
  logic [7:0] brg_q;                 // divider down counter
  logic       tick;                  // sixteen-times bit clock
  logic       ck_s1_q, ck_s2_q, ck_p_q;
  logic       rx_s1_q, rx_s2_q, rx_p_q;
  asu_state_e tx_st_q, rx_st_q;
  logic [3:0] tx_sub_q, rx_sub_q;    // ticks within a bit
  logic [3:0] tx_bit_q, rx_bit_q;    // bits within a field
  logic [8:0] tx_sh_q, rx_sh_q;      // shift registers
  logic       tx_par_q;              // parity bit to send
  logic       rx_fe_q;               // stop bit low seen
  logic       rx_pbit_q;             // received parity bit
  logic [7:0] rdata_q;
  logic       line_q, oe_q, txirq_q, rxirq_q;

  // decoded settings
  logic       mode_ok;
  logic [3:0] nbits;
  logic       msb_first;
  logic       two_stop;
  logic       par_en;
  logic       rd_hi;
  logic       tx_go, tx_end, rx_end, rx_ovr;
  logic       line_d;
  logic [8:0] rx_data;
  logic       rx_perr;

  always_comb begin
    mode_ok   = (mode_q[2:0] == MODE_7BIT) || (mode_q[2:0] == MODE_8BIT) ||
                (mode_q[2:0] == MODE_9BIT);
    nbits     = (mode_q[2:0] == MODE_7BIT) ? 4'h7 :
                (mode_q[2:0] == MODE_8BIT) ? 4'h8 : 4'h9;
    // (R17) msb first only at 8 bits
    msb_first = ctl0_q[C0_MSBF] && (mode_q[2:0] == MODE_8BIT);
    two_stop  = mode_q[MR_STOP];
    par_en    = mode_q[MR_PEN];
    rd_hi     = reg_rd_i && (reg_addr_i == ADDR_RB_HI);
  end

  // mask to the active width, unused bits zero
  function automatic logic [8:0] asu_mask(input logic [8:0] d, input logic [3:0] n);
    asu_mask = (n == 4'h7) ? {2'h0, d[6:0]} : (n == 4'h8) ? {1'h0, d[7:0]} : d;
  endfunction : asu_mask

  // swap bit order of the low byte
  function automatic logic [8:0] asu_rev8(input logic [8:0] d);
    logic [8:0] r;
    r = d;
    for (int k = 0; k < 8; k++) begin
      r[k] = d[7-k];
    end
    asu_rev8 = r;
  endfunction : asu_rev8

  // reset release through two stages
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // pin synchronisers; stage one feeds stage two only
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      {ck_s1_q, ck_s2_q, ck_p_q} <= 3'h0;
      {rx_s1_q, rx_s2_q, rx_p_q} <= 3'h7;
    end else begin
      ck_s1_q <= serial_clock_pin_i;
      ck_s2_q <= ck_s1_q;
      ck_p_q  <= ck_s2_q;
      rx_s1_q <= serial_in_pin_i;
      rx_s2_q <= rx_s1_q;
      rx_p_q  <= rx_s2_q;
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= RST_MODE;
      baud_q <= RST_BAUD;
      ctl0_q <= RST_CTL0;
      ctl1_q <= RST_CTL1;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_MODE) begin
        mode_q <= reg_wdata_i;
      end else if (reg_addr_i == ADDR_BAUD) begin
        baud_q <= reg_wdata_i;
      end else if (reg_addr_i == ADDR_CTL0) begin
        ctl0_q <= reg_wdata_i;
      end else if (reg_addr_i == ADDR_CTL1) begin
        ctl1_q <= reg_wdata_i;
      end
    end
  end

  // source tick and divider; external edge is the rising one
  logic src_tick;
  always_comb begin
    if (mode_q[MR_CLOCK_SOURCE_SEL]) begin
      // (R5) external clock pin edges
      src_tick = ck_s2_q && !ck_p_q;
    end else if (ctl0_q[1:0] == SRC_F1) begin
      src_tick = 1'b1;
    end else if (ctl0_q[1:0] == SRC_F8) begin
      src_tick = (pre_q[2:0] == PRE_F8[2:0]);
    end else begin
      src_tick = (pre_q == PRE_F32);
    end
  end

  // (R4) divide source by n+1
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 5'h00;
      brg_q <= 8'h00;
      tick  <= 1'b0;
    end else begin
      pre_q <= pre_q + 5'h01;
      tick  <= 1'b0;
      if (src_tick) begin
        if (brg_q == 8'h00) begin
          brg_q <= baud_q;
          tick  <= 1'b1;
        end else begin
          brg_q <= brg_q - 8'h01;
        end
      end
    end
  end

  // transmit start and end events
  always_comb begin
    // (R6) enable plus data waiting
    tx_go  = (tx_st_q == ASU_IDLE) && mode_ok && ctl1_q[C1_TXEN] && !tbe_q;
    tx_end = (tx_st_q == ASU_STOP) && tick && (tx_sub_q == OVS_LAST) &&
             (!two_stop || tx_bit_q == 4'h1);
  end

  // transmit buffer and its empty flag; a new write beats the load
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tb_q  <= 9'h000;
      tbe_q <= 1'b1;
    end else begin
      // (R23) empty once moved to shifter
      if (tx_go) begin
        tbe_q <= 1'b1;
      end
      if (reg_wr_i && reg_addr_i == ADDR_TB_HI) begin
        tb_q[8] <= reg_wdata_i[0];
      end
      // (R21) low byte write arms sending
      if (reg_wr_i && reg_addr_i == ADDR_TB_LO) begin
        tb_q[7:0] <= reg_wdata_i;
        tbe_q     <= 1'b0;
      end
    end
  end

  // transmit sequencer
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_q  <= ASU_IDLE;
      tx_sub_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q  <= 9'h000;
      tx_par_q <= 1'b0;
      shemp_q  <= 1'b1;
    end else begin
      case (tx_st_q)
        ASU_IDLE: begin
          if (tx_go) begin
            // (R17) reorder for msb first
            tx_sh_q  <= msb_first ? asu_rev8(tb_q) : asu_mask(tb_q, nbits);
            // (R2) even: ones total even
            tx_par_q <= (^asu_mask(tb_q, nbits)) ^ !mode_q[MR_PEVEN];
            tx_st_q  <= ASU_START;
            tx_sub_q <= 4'h0;
            shemp_q  <= 1'b0;
          end
        end
        ASU_START: begin
          if (tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == OVS_LAST) begin
              // (R1) start bit then data
              tx_st_q  <= ASU_DATA;
              tx_bit_q <= 4'h0;
            end
          end
        end
        ASU_DATA: begin
          if (tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == OVS_LAST) begin
              tx_sh_q  <= {1'b0, tx_sh_q[8:1]};
              tx_bit_q <= tx_bit_q + 4'h1;
              if (tx_bit_q == nbits - 4'h1) begin
                tx_st_q  <= par_en ? ASU_PAR : ASU_STOP;
                tx_bit_q <= 4'h0;
              end
            end
          end
        end
        ASU_PAR: begin
          if (tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == OVS_LAST) begin
              tx_st_q <= ASU_STOP;
            end
          end
        end
        ASU_STOP: begin
          if (tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == OVS_LAST) begin
              tx_bit_q <= tx_bit_q + 4'h1;
            end
          end
          // (R3) one or two stop bits
          if (tx_end) begin
            tx_st_q <= ASU_IDLE;
            // (R23) shift empty after last stop
            shemp_q <= 1'b1;
          end
        end
        default: begin
          tx_st_q <= ASU_IDLE;
        end
      endcase
    end
  end

  // line level; open drain only ever pulls low
  always_comb begin
    case (tx_st_q)
      ASU_START: line_d = 1'b0;
      ASU_DATA:  line_d = tx_sh_q[0];
      ASU_PAR:   line_d = tx_par_q;
      default:   line_d = 1'b1;
    endcase
  end

  // (R19) idle high or released
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      line_q <= 1'b1;
      oe_q   <= 1'b1;
    end else begin
      line_q <= line_d;
      oe_q   <= ctl0_q[C0_ODRAIN] ? !line_d : 1'b1;
    end
  end

  // transmit event pulse
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      txirq_q <= 1'b0;
    end else begin
      // (R8) (R9) source select picks moment
      txirq_q <= ctl1_q[C1_TXISEL] ? tx_end : tx_go;
    end
  end

  // receive result decode
  always_comb begin
    rx_data = (nbits == 4'h7) ? {2'h0, rx_sh_q[8:2]} :
              (nbits == 4'h8) ? {1'h0, rx_sh_q[8:1]} : rx_sh_q;
    if (msb_first) begin
      rx_data = asu_rev8(rx_data);
    end
    // (R14) ones over data plus parity
    rx_perr = par_en && ((^rx_data ^ rx_pbit_q) != !mode_q[MR_PEVEN]);
    rx_end  = (rx_st_q == ASU_STOP) && tick && (rx_sub_q == OVS_MID) &&
              (!two_stop || rx_bit_q == 4'h1);
    // (R11) unread buffer at frame end
    rx_ovr  = rx_end && rxdone_q;
  end

  // receive sequencer
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q   <= ASU_IDLE;
      rx_sub_q  <= 4'h0;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 9'h000;
      rx_fe_q   <= 1'b0;
      rx_pbit_q <= 1'b0;
    end else begin
      if (tick && rx_st_q != ASU_IDLE) begin
        rx_sub_q <= rx_sub_q + 4'h1;
      end
      case (rx_st_q)
        ASU_IDLE: begin
          // (R7) (R22) enabled, falling edge
          if (mode_ok && ctl1_q[C1_RXEN] && rx_p_q && !rx_s2_q) begin
            rx_st_q  <= ASU_START;
            rx_sub_q <= 4'h0;
            rx_fe_q  <= 1'b0;
          end
        end
        ASU_START: begin
          // (R22) mid start bit recheck
          if (tick && rx_sub_q == OVS_MID) begin
            rx_st_q  <= rx_s2_q ? ASU_IDLE : ASU_DATA;
            rx_bit_q <= 4'h0;
          end
        end
        ASU_DATA: begin
          if (tick && rx_sub_q == OVS_MID) begin
            rx_sh_q  <= {rx_s2_q, rx_sh_q[8:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == nbits - 4'h1) begin
              rx_st_q  <= par_en ? ASU_PAR : ASU_STOP;
              rx_bit_q <= 4'h0;
            end
          end
        end
        ASU_PAR: begin
          if (tick && rx_sub_q == OVS_MID) begin
            rx_pbit_q <= rx_s2_q;
            rx_st_q   <= ASU_STOP;
          end
        end
        ASU_STOP: begin
          if (tick && rx_sub_q == OVS_MID) begin
            rx_bit_q <= rx_bit_q + 4'h1;
            // (R13) any low stop bit
            if (!rx_s2_q) begin
              rx_fe_q <= 1'b1;
            end
          end
          if (rx_end) begin
            rx_st_q <= ASU_IDLE;
          end
        end
        default: begin
          rx_st_q <= ASU_IDLE;
        end
      endcase
    end
  end

  // receive buffer and flags; hardware set wins over read clear
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rb_q     <= 9'h000;
      rxdone_q <= 1'b0;
      ovr_q    <= 1'b0;
      fer_q    <= 1'b0;
      per_q    <= 1'b0;
      rxirq_q  <= 1'b0;
    end else begin
      rxirq_q <= 1'b0;
      // (R20) upper read clears done, framing and parity flags
      if (rd_hi) begin
        rxdone_q <= 1'b0;
        fer_q    <= 1'b0;
        per_q    <= 1'b0;
      end
      if (!ctl1_q[C1_RXEN]) begin
        ovr_q <= 1'b0;
      end
      if (rx_ovr) begin
        // (R12) data undefined, no request
        ovr_q <= 1'b1;
        rb_q  <= rx_data;
      end else if (rx_end) begin
        // (R10) (R18) load buffer, request
        rb_q     <= rx_data;
        rxdone_q <= 1'b1;
        rxirq_q  <= 1'b1;
        fer_q    <= rx_fe_q || !rx_s2_q;
        per_q    <= rx_perr;
      end
    end
  end

  // read data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= 8'h00;
      if (reg_rd_i) begin
        if (reg_addr_i == ADDR_MODE) begin
          rdata_q <= mode_q;
        end else if (reg_addr_i == ADDR_BAUD) begin
          rdata_q <= baud_q;
        end else if (reg_addr_i == ADDR_CTL0) begin
          rdata_q <= ctl0_q;
          rdata_q[C0_SHEMPTY] <= shemp_q;
        end else if (reg_addr_i == ADDR_CTL1) begin
          rdata_q <= ctl1_q;
          rdata_q[C1_TBE]    <= tbe_q;
          rdata_q[C1_RXDONE] <= rxdone_q;
        end else if (reg_addr_i == ADDR_RB_LO) begin
          rdata_q <= rb_q[7:0];
        end else if (reg_addr_i == ADDR_RB_HI) begin
          rdata_q[0]      <= rb_q[8];
          rdata_q[RB_OVR] <= ovr_q;
          rdata_q[RB_FER] <= fer_q;
          rdata_q[RB_PER] <= per_q;
          // (R15) sum of all errors
          rdata_q[RB_SUM] <= ovr_q || fer_q || per_q;
        end
      end
    end
  end

  assign reg_rdata_o         = rdata_q;
  assign serial_out_pin_o    = line_q;
  assign serial_out_pin_oe_o = oe_q;
  assign tx_irq_o            = txirq_q;
  assign rx_irq_o            = rxirq_q;

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_tx_load;
    tx_go;
  endsequence
  sequence s_start_low;
    !line_q [*2];
  endsequence

  // a low-byte write in the load cycle keeps the buffer full on purpose
  AST_TX_GO: assert property (s_tx_load and !(reg_wr_i && reg_addr_i == ADDR_TB_LO) // (R6)
                              |=> tbe_q && !shemp_q)
    else $error("transmit load did not update flags");
  AST_TX_STARTBIT: assert property (s_tx_load ##1 1'b1 |=> s_start_low) // (R1)
    else $error("start bit not driven low");
  AST_TX_IRQ0: assert property (s_tx_load and !ctl1_q[C1_TXISEL] |=> tx_irq_o) // (R8)
    else $error("missing buffer-empty request");
  AST_TX_IRQ1: assert property (tx_end && ctl1_q[C1_TXISEL] |=> tx_irq_o && shemp_q) // (R9)
    else $error("missing transfer-end request");
  AST_RX_IRQ: assert property (rx_end && !rxdone_q |=> rx_irq_o && rxdone_q) // (R10)
    else $error("receive end without request");
  AST_RX_OVR: assert property (rx_ovr |=> ovr_q && !rx_irq_o) // (R11)
    else $error("overrun handling wrong");
  AST_RX_CLR: assert property (rd_hi && !rx_end |=> !rxdone_q && !fer_q && !per_q) // (R20)
    else $error("upper read did not clear flags");
  AST_RX_EN: assert property (rx_st_q == ASU_IDLE && !ctl1_q[C1_RXEN] |=> // (R7)
                              rx_st_q == ASU_IDLE)
    else $error("receive started while disabled");
  AST_IDLE_HIGH: assert property (tx_st_q == ASU_IDLE && $past(tx_st_q) == ASU_IDLE // (R19)
                                  |-> line_q)
    else $error("idle line not high");
  AST_SUM: assert property (reg_rd_i && reg_addr_i == ADDR_RB_HI && (fer_q || per_q) // (R15)
                            |=> reg_rdata_o[RB_SUM])
    else $error("error sum not reported");
endmodule : asuart_top

/* File: tb/asuart_peer.sv */
module asuart_peer (
  // clock and line from the block
  input  wire logic        clk_i,
  input  wire logic        line_i,
  // framing set-up
  input  wire logic [9:0]  bit_cyc_i,
  input  wire logic [3:0]  nbits_i,
  // serial drive and capture
  output logic             rxd_o,
  output logic [11:0]      word_o,
  output logic             word_vld_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // line idles at mark level
  initial rxd_o <= 1'b1;
  // start on a falling edge, each bit taken at its middle
  initial begin : capture
    logic        prev;
    logic [11:0] w;
    prev = 1'b1;
    word_vld_o <= 1'b0;
    word_o <= '0;
    forever begin
      @(posedge clk_i);
      word_vld_o <= 1'b0;
      if (prev && !line_i) begin
        w = '0;
        repeat (bit_cyc_i / 2) @(posedge clk_i);
        for (int k = 0; k < nbits_i; k++) begin
          repeat (bit_cyc_i) @(posedge clk_i);
          w[k] = line_i;
        end
        word_o <= w;
        word_vld_o <= 1'b1;
      end
      prev = line_i;
    end
  end : capture
  // start bit, then n bits of w lsb first, then back to mark
  task automatic send(input logic [11:0] w, input int n);
    @(posedge clk_i);
    rxd_o <= 1'b0;
    repeat (bit_cyc_i) @(posedge clk_i);
    for (int k = 0; k < n; k++) begin
      rxd_o <= w[k];
      repeat (bit_cyc_i) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask : send
endmodule : asuart_peer

/* File: tb/async_serial_uart_mode_tb.sv */
module async_serial_uart_mode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import asuart_pkg::*;
  // format table: mode, control zero, divider, bit length, error kind
  localparam logic [7:0] MR_T   [6] = '{8'h64, 8'h15, 8'h46, 8'h05, 8'h0d, 8'h05};
  localparam logic [7:0] C0_T   [6] = '{8'h00, 8'h00, 8'h01, 8'ha0, 8'h00, 8'h02};
  localparam logic [7:0] BRG_T  [6] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [9:0] BC_T   [6] = '{10'h010, 10'h030, 10'h080, 10'h010, 10'h040, 10'h200};
  localparam int         ERR_T  [6] = '{1, 2, 1, 3, 0, 0};
  localparam logic [7:0] ERRV_T [4] = '{8'h00, 8'hc0, 8'ha0, 8'h90};
  // stimulus and observed signals
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        sclk = 1'b0;
  logic        rd_taken = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic        rxd, txd, txd_oe, tx_irq, rx_irq, line, wvld;
  logic [11:0] word;
  logic [9:0]  bc = 10'h010;
  logic [3:0]  nw = 4'h0;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          n_tx = 0;
  int          n_rx = 0;
  int          n_wd = 0;
  logic [15:0] rq[$];  // expected read value and mask
  logic [11:0] sq[$];  // expected serial words
  always #20 clk = ~clk;
  // external count clock, four system clock periods, edges on system clock falling edges
  always #80 sclk = ~sclk;
  // released open-drain line is pulled up
  assign line = txd_oe ? txd : 1'b1;
  asuart_top asuart_top_inst (.sys_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .serial_in_pin_i(rxd), .serial_clock_pin_i(sclk), .serial_out_pin_o(txd),
    .serial_out_pin_oe_o(txd_oe), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));
  asuart_peer asuart_peer_inst (.clk_i(clk), .line_i(line), .bit_cyc_i(bc), .nbits_i(nw),
    .rxd_o(rxd), .word_o(word), .word_vld_o(wvld));
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    rq.push_back({e & m, m});
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  // bounded wait for an event counter to reach its target
  task automatic wait_cnt(ref int c, input int target);
    int t;
    t = 0;
    while (c < target && t < 30000) begin
      @(posedge clk);
      t++;
    end
    if (c < target) begin
      n_errors++;
      complete_run();
    end
  endtask : wait_cnt
  // character bits in wire order, parity, stops; bad 1 flips parity, 2 drops last stop
  function automatic logic [11:0] frame_word(logic [8:0] d, int nb, logic ms, int pe, int pv,
                                             int st, int bad);
    logic [11:0] w;
    w = '0;
    for (int k = 0; k < nb; k++) w[k] = ms ? d[7-k] : d[k];
    if (pe != 0) w[nb] = (^d) ^ (pv == 0) ^ (bad == 1);
    for (int k = 0; k < st; k++) w[nb+pe+k] = 1'b1;
    if (bad == 2) w[nb+pe+st-1] = 1'b0;
    return w;
  endfunction : frame_word
  // event counters and serial word compare
  always @(posedge clk) begin
    rd_taken <= rd;
    if (tx_irq === 1'b1) n_tx++;
    if (rx_irq === 1'b1) n_rx++;
    if (wvld === 1'b1) begin
      chk(word, sq.size() > 0 ? sq.pop_front() : 12'hxxx);
      n_wd++;
    end
  end
  // read data stands only in the cycle after the strobe
  always @(negedge clk) begin
    if (rd_taken) begin
      chk({4'h0, rdata & rq[0][7:0]}, {4'h0, rq[0][15:8]});
      void'(rq.pop_front());
    end
  end
  initial begin : main
    logic [8:0] d;
    logic [7:0] mr, c0;
    int nb, pe, pv, st, n, err, ex_tx, ex_rx, ex_wd;
    void'($urandom(92017));
    ex_tx = 0;
    ex_rx = 0;
    ex_wd = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(ADDR_MODE, RST_MODE, 8'hff);
    rd_reg(ADDR_BAUD, RST_BAUD, 8'hff);
    rd_reg(ADDR_CTL0, RST_CTL0 | 8'h08, 8'hff);
    rd_reg(ADDR_CTL1, RST_CTL1 | 8'h02, 8'hff);
    rd_reg(ADDR_RB_HI, 8'h00, 8'hff);
    rd_reg(ADDR_TB_LO, 8'h00, 8'hff);
    for (int i = 0; i < 6; i++) begin
      mr = MR_T[i];
      c0 = C0_T[i];
      err = ERR_T[i];
      nb = (mr[2:0] == MODE_7BIT) ? 7 : (mr[2:0] == MODE_8BIT) ? 8 : 9;
      pe = mr[MR_PEN];
      pv = mr[MR_PEVEN];
      st = mr[MR_STOP] + 1;
      n = nb + pe + st;
      nw <= 4'(n);
      bc <= BC_T[i];
      // disabling first also clears a standing overrun
      wr_reg(ADDR_CTL1, 8'h00);
      wr_reg(ADDR_MODE, mr);
      wr_reg(ADDR_CTL0, c0);
      wr_reg(ADDR_BAUD, BRG_T[i]);
      d = 9'($urandom % (1 << nb));
      if (nb == 9) wr_reg(ADDR_TB_HI, {7'h00, d[8]});
      wr_reg(ADDR_TB_LO, d[7:0]);
      repeat (20) @(posedge clk);
      rd_reg(ADDR_CTL1, 8'h00, 8'h02);
      @(negedge clk);
      chk({10'h0, txd_oe, txd}, {10'h0, ~c0[C0_ODRAIN], 1'b1});
      sq.push_back(frame_word(d, nb, c0[C0_MSBF], pe, pv, st, 0));
      ex_tx++;
      ex_wd++;
      wr_reg(ADDR_CTL1, (i % 2) ? 8'h15 : 8'h05);
      wait_cnt(n_tx, ex_tx);
      rd_reg(ADDR_CTL0, (i % 2) ? 8'h08 : 8'h00, 8'h08);
      rd_reg(ADDR_CTL1, 8'h02, 8'h02);
      wait_cnt(n_wd, ex_wd);
      d = 9'($urandom % (1 << nb));
      asuart_peer_inst.send(frame_word(d, nb, c0[C0_MSBF], pe, pv, st, 0), n);
      ex_rx++;
      wait_cnt(n_rx, ex_rx);
      rd_reg(ADDR_RB_LO, d[7:0], nb == 7 ? 8'h7f : 8'hff);
      rd_reg(ADDR_RB_HI, {7'h00, d[8]}, nb == 9 ? 8'h71 : 8'h70);
      if (err > 0) begin
        asuart_peer_inst.send(frame_word(d, nb, c0[C0_MSBF], pe, pv, st, err % 3), n);
        if (err == 3) asuart_peer_inst.send(frame_word(d, nb, c0[C0_MSBF], pe, pv, st, 0), n);
        ex_rx++;
        wait_cnt(n_rx, ex_rx);
        repeat (8) @(posedge clk);
        chk(12'(n_rx), 12'(ex_rx));
        rd_reg(ADDR_RB_HI, ERRV_T[err], 8'hf0);
      end
    end
    repeat (4) @(posedge clk);
    chk(12'(n_tx), 12'(ex_tx));
    complete_run();
  end : main
endmodule : async_serial_uart_mode_tb
